/* logic/tti_top.sv */
/*
  Threshold interrupt enables and general-purpose pin setup of a touch
  controller, with an APB register slave, sticky event status, mask and
  one active-low interrupt output.
  Assumes threshold events arrive as pulses synchronous to pclk.
*/
// Chosen here: the APB slave port.
// Summary of operation
// - stages 8-11 low-threshold events reach the interrupt when low enables 8-11 are set
// - pin function field 13:12: off, input, active-low out, active-high out
// - pin trigger field 15:14: low level, rising, falling, high level
// - twelve high-event enables at bits 11:0 of index 0x006; upper bits not stored and read zero
// - all enables and pin fields reset to zero
// - low enables for stages 0-7 at bits 0-7 gate their low events
// - completion-enable bit 12 lets a pin trigger assert the interrupt
`timescale 1ns/1ps
module tti_top
  import tti_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // threshold events from the comparators
  input wire logic [STAGES-1:0] low_event,
  input wire logic [STAGES-1:0] high_event,
  // general-purpose pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // interrupt
  output logic irq_n
);
  logic [15:0] low_en_reg;
  logic [11:0] high_en_reg;
  logic [DONE_EN_W-1:0] done_en_reg;
  logic [EVT_W-1:0] stat_reg;
  logic [EVT_W-1:0] stat_next;
  logic [EVT_W-1:0] mask_reg;
  logic drive_reg;
  logic irq_reg;
  logic [31:0] rdata_next;

  tti_pin_if pif();

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // decode
  wire sel_low = hit(paddr, IDX_LOW_EN);
  wire sel_high = hit(paddr, IDX_HIGH_EN);
  wire sel_done = hit(paddr, IDX_DONE_EN);
  wire sel_stat = hit(paddr, IDX_EVT_STAT);
  wire sel_mask = hit(paddr, IDX_EVT_MASK);
  wire sel_drv = hit(paddr, IDX_PIN_DRIVE);
  wire mapped = sel_low | sel_high | sel_done | sel_stat | sel_mask | sel_drv;
  wire access = psel & penable;
  wire wr = access & pwrite & mapped;
  wire setup = psel & ~penable;

  // zero-wait slave; error only on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // pin configuration out to the pin logic
  assign pif.func = low_en_reg[PIN_FUNC_LSB +: 2];
  assign pif.trig = low_en_reg[PIN_TRIG_LSB +: 2];
  assign pif.drive = drive_reg;

  tti_pin u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(pif.pin),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // raw events captured whatever the enables; enables act at the output
  wire [EVT_W-1:0] evt_in = {pif.trigger, high_event, low_event};
  // source gate: low enables 0-11, high enables 0-11, pin event enable
  wire [EVT_W-1:0] src_en = {done_en_reg[PIN_EVT_EN_BIT], high_en_reg, low_en_reg[LOW_EN_LSB +: STAGES]};
  wire [EVT_W-1:0] stat_clr = (wr & sel_stat) ? pwdata[EVT_W-1:0] : '0;
  // set wins over a write-one-to-clear in the same cycle
  assign stat_next = (stat_reg & ~stat_clr) | evt_in;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (sel_low) begin
      rdata_next[15:0] = low_en_reg;
    end
    if (sel_high) begin
      rdata_next[11:0] = high_en_reg;
    end
    if (sel_done) begin
      rdata_next[DONE_EN_W-1:0] = done_en_reg;
    end
    if (sel_stat) begin
      rdata_next[EVT_W-1:0] = stat_reg;
    end
    if (sel_mask) begin
      rdata_next[EVT_W-1:0] = mask_reg;
    end
    if (sel_drv) begin
      rdata_next[0] = drive_reg;
    end
  end

  // read data is captured in the setup cycle so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_en_reg <= LOW_EN_RST;
      high_en_reg <= HIGH_EN_RST;
      done_en_reg <= DONE_EN_RST;
      mask_reg <= EVT_MASK_RST;
      drive_reg <= 1'b0;
    end else if (wr) begin
      if (sel_low) low_en_reg <= pwdata[15:0];
      // bits 15:12 of the high enables are not stored and read zero
      if (sel_high) high_en_reg <= pwdata[11:0];
      if (sel_done) done_en_reg <= pwdata[DONE_EN_W-1:0];
      if (sel_mask) mask_reg <= pwdata[EVT_W-1:0];
      if (sel_drv) drive_reg <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_reg & src_en);
    end
  end

  // registered so the pad never glitches; built from stat_next so it follows pending on the same edge
  assign irq_n = ~irq_reg;
endmodule

/* logic/tti_pkg.sv */
/*
  Constants shared by the touch threshold interrupt block: register indexes,
  field positions, reset values and pin function codes.
  Assumes a 32-bit APB with byte addresses equal to four times a register index.
*/
package tti_pkg;
  localparam int ADDR_W = 12;
  localparam int STAGES = 12;
  localparam int EVT_W = 25;

  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_LOW_EN = 10'h005;
  localparam logic [9:0] IDX_HIGH_EN = 10'h006;
  localparam logic [9:0] IDX_DONE_EN = 10'h007;
  localparam logic [9:0] IDX_EVT_STAT = 10'h040;
  localparam logic [9:0] IDX_EVT_MASK = 10'h041;
  localparam logic [9:0] IDX_PIN_DRIVE = 10'h042;

  // fields of the low-event enable and pin setup register
  localparam int LOW_EN_LSB = 0;
  localparam int PIN_FUNC_LSB = 12;
  localparam int PIN_TRIG_LSB = 14;
  // completion enable register: only the pin event enable acts here
  localparam int DONE_EN_W = 13;
  localparam int PIN_EVT_EN_BIT = 12;

  // event status / mask layout
  localparam int EVT_LOW_LSB = 0;
  localparam int EVT_HIGH_LSB = 12;
  localparam int EVT_PIN_BIT = 24;

  // reset values
  localparam logic [15:0] LOW_EN_RST = 16'h0000;
  localparam logic [11:0] HIGH_EN_RST = 12'h000;
  localparam logic [12:0] DONE_EN_RST = 13'h0000;
  localparam logic [24:0] EVT_MASK_RST = 25'h1ffffff;

  typedef enum logic [1:0] {
    PIN_OFF = 2'h0,
    PIN_INPUT = 2'h1,
    PIN_OUT_LOW = 2'h2,
    PIN_OUT_HIGH = 2'h3
  } tti_pin_func_e;

  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL = 2'h0,
    TRIG_RISE = 2'h1,
    TRIG_FALL = 2'h2,
    TRIG_HIGH_LEVEL = 2'h3
  } tti_pin_trig_e;
endpackage

/* logic/tti_pin_if.sv */
/*
  Carrier between the register block and the pin logic: pin configuration
  and pin drive one way, trigger the other way.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface tti_pin_if;
  logic [1:0] func;
  logic [1:0] trig;
  logic drive;
  logic trigger;
  modport ctl (output func, output trig, output drive, input trigger);
  modport pin (input func, input trig, input drive, output trigger);
endinterface

/* logic/tti_pin.sv */
/*
  General-purpose pin logic: function select, output polarity and input
  trigger detection.
  Assumes the pin input is synchronous to pclk.
*/
`timescale 1ns/1ps
module tti_pin
  import tti_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  tti_pin_if.pin cfg,
  // pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  logic prev_reg;
  wire is_input = (cfg.func == PIN_INPUT);
  wire rise = pin_in & ~prev_reg;
  wire fall = ~pin_in & prev_reg;
  logic cond;

  always_comb begin
    case (tti_pin_trig_e'(cfg.trig))
      TRIG_LOW_LEVEL: cond = ~pin_in;
      TRIG_RISE: cond = rise;
      TRIG_FALL: cond = fall;
      TRIG_HIGH_LEVEL: cond = pin_in;
      default: cond = 1'b0;
    endcase
  end

  // trigger only counts while the pin is an input
  assign cfg.trigger = is_input & cond;

  // edge history; edges only count once the pin is set up as an input, which takes a bus write,
  // so the reset value is long gone before it could matter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_in;
    end
  end

  // active-low output drives the inverse of the drive request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= (cfg.func == PIN_OUT_LOW) | (cfg.func == PIN_OUT_HIGH);
      pin_out <= (cfg.func == PIN_OUT_LOW) ? ~cfg.drive : cfg.drive;
    end
  end
endmodule

/* testbench/tti_checker.sv */
/* Checker of the tti_top ports.
   Assumes it is bound to tti_top and sees its ports only. */
`timescale 1ns/1ps
module tti_checker (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin, irq
  input wire logic pin_oe,
  input wire logic irq_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_odd; acc && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0; endproperty
  a_odd: assert property (p_odd) else $error("odd address taken");
  property p_map; acc && paddr inside {12'h014, 12'h018, 12'h01c, 12'h100} |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_hi; acc && !pwrite && paddr == 12'h018 |-> prdata[31:12] == 20'h0; endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  property p_oe; $rose(pin_oe) |-> $past(wr && paddr == 12'h014 && pwdata[13], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin drive unasked");
  property p_rel; $rose(irq_n) |-> $past(wr) || $past(wr, 2); endproperty
  a_rel: assert property (p_rel) else $error("irq dropped alone");
  property p_rst; $rose(presetn) |-> irq_n && !pin_oe; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind tti_top tti_checker chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .pin_oe(pin_oe),
  .irq_n(irq_n)
);

/* testbench/tti_host_model.sv */
/* Host model: APB master of the register bus.
   Assumes pready within 50 cycles, else hung is set. */
`timescale 1ns/1ps
module tti_host_model (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung = 1'b0;
  logic err = 1'b0;
  logic [31:0] q = 32'h0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a == 12'h018) ? d & 32'h0fff : d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (!pready) hung = 1'b1;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* testbench/test_touch_threshold_irq_enable_gpio_cfg.sv */
/* Bench of tti_top: registers, events, pin setup, triggers.
   Assumes tti_host_model drives the bus. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module test_touch_threshold_irq_enable_gpio_cfg;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] low_event = 12'h0;
  logic [11:0] high_event = 12'h0;
  logic ext_in = 1'b0;
  wire logic psel, penable, pwrite, pready, pslverr, pin_out, pin_oe, irq_n;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  // far side drives the pad only while the device has released it
  wire logic pin_in = pin_oe ? pin_out : ext_in;
  int miscompares = 0;
  int samples_checked = 0;
  always #5 pclk = ~pclk;
  tti_top dut (.*);
  tti_host_model host (.*);
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic x);
    host.xfer(1'b0, a, 32'h0);
    `CHK("prdata", e, host.q)
    `CHK("pslverr", x, host.err)
  endtask
  task automatic wi(input logic [11:0] a, input logic [31:0] d, input logic e);
    host.xfer(1'b1, a, d);
    @(posedge pclk);
    #1;
    `CHK("irq_n", e, irq_n)
  endtask
  task automatic ev(input logic h, input int s, input logic e);
    @(posedge pclk);
    if (h) high_event[s] <= 1'b1;
    else low_event[s] <= 1'b1;
    @(posedge pclk);
    low_event <= 12'h0;
    high_event <= 12'h0;
    #1;
    `CHK("irq_n", e, irq_n)
  endtask
  task automatic finish_test();
    if (host.hung) miscompares++;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 20000 && !host.hung; i++) begin
      @(posedge pclk);
    end
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h014, 32'h0, 1'b0);
    rd(12'h018, 32'h0, 1'b0);
    rd(12'h104, 32'h01ffffff, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    rd(12'h016, 32'h0, 1'b1);
    host.xfer(1'b1, 12'h018, 32'h0000ffff);
    rd(12'h018, 32'h00000fff, 1'b0);
    for (int s = 0; s < 12; s++) begin
      for (int h = 0; h < 2; h++) begin
        host.xfer(1'b1, h ? 12'h018 : 12'h014, 32'h1 << s);
        host.xfer(1'b1, h ? 12'h014 : 12'h018, 32'h0);
        ev(h, (s + 1) % 12, 1'b1);
        rd(12'h100, 32'h1 << ((s + 1) % 12 + 12 * h), 1'b0);
        ev(h, s, 1'b0);
        wi(12'h104, 32'h0, 1'b1);
        wi(12'h104, 32'h01ffffff, 1'b0);
        wi(12'h100, 32'h01ffffff, 1'b1);
      end
    end
    host.xfer(1'b1, 12'h108, 32'h1);
    for (int f = 0; f < 4; f++) begin
      host.xfer(1'b1, 12'h014, f << 12);
      @(posedge pclk);
      #1;
      `CHK("pin_oe", f[1], pin_oe)
      if (f[1]) `CHK("pin_out", f[0], pin_out)
    end
    host.xfer(1'b1, 12'h01c, 32'h1000);
    for (int t = 0; t < 4; t++) begin
      @(posedge pclk);
      ext_in <= ~t[0];
      host.xfer(1'b1, 12'h014, 32'h1000 | (t << 14));
      wi(12'h100, 32'h01ffffff, 1'b1);
      @(posedge pclk);
      ext_in <= t[0];
      repeat (2) @(posedge pclk);
      #1;
      `CHK("irq_n", 1'b0, irq_n)
      @(posedge pclk);
      ext_in <= ~t[0];
      wi(12'h100, 32'h01ffffff, 1'b1);
    end
    finish_test();
  end
endmodule
